/* File: design/dpax_page_ext.v */
`timescale 1ns/1ps
`include "dpax_defines.vh"


// ****************************************************************
// Data page address extension
// ****************************************************************
module dpax_page_ext #(
  parameter PAGE_W = `DPAX_PAGE_W,
  parameter EA_W = `DPAX_EA_W
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // Selector loads from the core.
  input wire rdPageWrEn,
  input wire wrPageWrEn,
  input wire [PAGE_W-1:0] pageWrData,
  // Access request from address generation.
  input wire accValid,
  input wire accWrite,
  input wire [`DPAX_MODE_W-1:0] accMode,
  input wire [EA_W-1:0] baseEa,
  input wire [EA_W-1:0] modEa,
  input wire accOverflow,
  input wire accUnderflow,
  // Result towards the load/store unit.
  output reg ansValid_q,
  output reg [EA_W-1:0] ansEa_q,
  output reg [PAGE_W-1:0] ansPage_q,
  output reg ansPaged_q,
  output reg addrErrTrap_q,
  // Registered selector values, one cycle behind the selectors.
  output reg [PAGE_W-1:0] readPageSelector_q,
  output reg [PAGE_W-1:0] writePageSelector_q
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // True for a program-space visibility page value.
  function isVisPage;
    input [PAGE_W-1:0] pg;
    begin
      isVisPage = pg[`DPAX_VIS_BIT];
    end
  endfunction

  // True for a mode that walks the page selector on a wrap.
  function isWalkMode;
    input [`DPAX_MODE_W-1:0] m;
    begin
      isWalkMode = (m == `DPAX_MODE_PREMOD) || (m == `DPAX_MODE_POSTMOD);
    end
  endfunction

  // True for a mode that wraps within the current page.
  function isWrapMode;
    input [`DPAX_MODE_W-1:0] m;
    begin
      isWrapMode = (m == `DPAX_MODE_REGOFS) || (m == `DPAX_MODE_MODULO) ||
        (m == `DPAX_MODE_BITREV);
    end
  endfunction

  // ****************************************************************
  // Page selectors
  // ****************************************************************

  wire [PAGE_W-1:0] rdPage; // Read selector value.
  wire [PAGE_W-1:0] wrPage; // Write selector value.
  reg rdInc; // Read selector step up.
  reg rdDec; // Read selector step down.
  reg wrInc; // Write selector step up.
  reg wrDec; // Write selector step down.

  // Two independent selectors so one instruction reads one page and writes another.
  dpax_page_reg #(.PAGE_W(PAGE_W)) uRdPage (
    .sys_clk(sys_clk),
    .rst(rst),
    .loadEn(rdPageWrEn),
    .loadVal(pageWrData),
    .incEn(rdInc),
    .decEn(rdDec),
    .page_q(rdPage)
  );

  dpax_page_reg #(.PAGE_W(PAGE_W)) uWrPage (
    .sys_clk(sys_clk),
    .rst(rst),
    .loadEn(wrPageWrEn),
    .loadVal(pageWrData),
    .incEn(wrInc),
    .decEn(wrDec),
    .page_q(wrPage)
  );

  // ****************************************************************
  // Address correction
  // ****************************************************************

  reg [PAGE_W-1:0] actPage; // Active page selector for this access.
  reg paged; // Unmodified address lies in the paged window.
  reg wrapHit; // A wrap this access must act on.
  reg [EA_W-1:0] ansEa_d; // Corrected address.
  reg [PAGE_W-1:0] ansPage_d; // Page used for the access.
  reg ansPaged_d; // Access lands in the paged window.
  reg addrErrTrap_d; // Address error.
  reg stepUp; // Step active selector up.
  reg stepDn; // Step active selector down.

  // Works out the corrected address, page step and trap for one access.
  always @* begin
    actPage = accWrite ? wrPage : rdPage;
    paged = baseEa[`DPAX_EA_TOP];
    wrapHit = paged && (accOverflow || accUnderflow);
    ansEa_d = modEa;
    ansPage_d = actPage;
    stepUp = 1'b0;
    stepDn = 1'b0;
    addrErrTrap_d = 1'b0;
    // A wrapped calculation starts from a cleared bit 15.
    if (wrapHit) begin
      ansEa_d[`DPAX_EA_TOP] = 1'b0;
    end
    if (wrapHit && isWrapMode(accMode)) begin
      // Stay on the page, back into the window.
      ansEa_d[`DPAX_EA_TOP] = 1'b1;
    end else if (wrapHit && isWalkMode(accMode)) begin
      if (accOverflow) begin
        if (actPage == `DPAX_EXT_LAST) begin
          // Leaving the last data page drops to base space.
          ansEa_d[`DPAX_EA_TOP] = 1'b0;
        end else if (!accWrite && actPage == `DPAX_VIS_HIGH_LAST) begin
          ansEa_d[`DPAX_EA_TOP] = 1'b0;
        end else begin
          // Includes 0x2FF to 0x300 crossing with bit 15 kept.
          stepUp = 1'b1;
          ansPage_d = actPage + `DPAX_PAGE_ONE;
          ansEa_d[`DPAX_EA_TOP] = 1'b1;
        end
      end else begin
        if (!accWrite && (actPage == `DPAX_PAGE_ONE ||
            actPage == `DPAX_VIS_LOW_FIRST)) begin
          ansEa_d[`DPAX_EA_TOP] = 1'b0;
        end else begin
          // Includes 0x300 to 0x2FF crossing with bit 15 kept.
          stepDn = 1'b1;
          ansPage_d = actPage - `DPAX_PAGE_ONE;
          ansEa_d[`DPAX_EA_TOP] = 1'b1;
        end
      end
    end
    ansPaged_d = ansEa_d[`DPAX_EA_TOP];
    // A paged access on page zero has no backing page.
    if (ansPaged_d && ansPage_d == `DPAX_PAGE_ZERO) begin
      addrErrTrap_d = 1'b1;
    end
    // Program space is read-only through the paged window.
    if (ansPaged_d && accWrite && isVisPage(ansPage_d)) begin
      addrErrTrap_d = 1'b1;
    end
    // A trapped access leaves the selectors untouched.
    if (!accValid || addrErrTrap_d) begin
      stepUp = 1'b0;
      stepDn = 1'b0;
    end
    rdInc = stepUp && !accWrite;
    rdDec = stepDn && !accWrite;
    wrInc = stepUp && accWrite;
    wrDec = stepDn && accWrite;
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************

  // Results are registered so every output comes from a flip-flop.
  always @(posedge sys_clk) begin
    if (rst) begin
      ansValid_q <= 1'b0;
      ansEa_q <= {EA_W{1'b0}};
      ansPage_q <= `DPAX_PAGE_RST;
      ansPaged_q <= 1'b0;
      addrErrTrap_q <= 1'b0;
      readPageSelector_q <= `DPAX_PAGE_RST;
      writePageSelector_q <= `DPAX_PAGE_RST;
    end else begin
      ansValid_q <= accValid;
      ansEa_q <= ansEa_d;
      ansPage_q <= ansPage_d;
      ansPaged_q <= ansPaged_d;
      addrErrTrap_q <= accValid && addrErrTrap_d;
      // Mirrors are registered copies of the selector registers, one cycle behind them.
      readPageSelector_q <= rdPage;
      writePageSelector_q <= wrPage;
    end
  end

endmodule

/* File: design/dpax_page_reg.v */
`timescale 1ns/1ps
`include "dpax_defines.vh"

// ****************************************************************
// One page selector register with load and step
// ****************************************************************
module dpax_page_reg #(
  parameter PAGE_W = `DPAX_PAGE_W
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // Software load of the selector.
  input wire loadEn,
  input wire [PAGE_W-1:0] loadVal,
  // Hardware step from the address unit.
  input wire incEn,
  input wire decEn,
  // Current value.
  output reg [PAGE_W-1:0] page_q
);

  // Selector state; a load wins over a step since software owns the value.
  always @(posedge sys_clk) begin
    if (rst) begin
      page_q <= `DPAX_PAGE_RST;
    end else if (loadEn) begin
      page_q <= loadVal;
    end else if (incEn) begin
      page_q <= page_q + `DPAX_PAGE_ONE;
    end else if (decEn) begin
      page_q <= page_q - `DPAX_PAGE_ONE;
    end
  end

endmodule

/* File: inc/dpax_defines.vh */
`ifndef DPAX_DEFINES_VH
`define DPAX_DEFINES_VH

// ****************************************************************
// Page selector geometry and reset values
// ****************************************************************
`define DPAX_PAGE_W 10
`define DPAX_EA_W 16
`define DPAX_EA_TOP 15
`define DPAX_PAGE_RST 10'h001
`define DPAX_PAGE_ZERO 10'h000
`define DPAX_PAGE_ONE 10'h001

// ****************************************************************
// Page boundary values
// ****************************************************************
`define DPAX_EXT_LAST 10'h1FF
`define DPAX_VIS_LOW_FIRST 10'h200
`define DPAX_VIS_LOW_LAST 10'h2FF
`define DPAX_VIS_HIGH_FIRST 10'h300
`define DPAX_VIS_HIGH_LAST 10'h3FF
`define DPAX_VIS_BIT 9

// ****************************************************************
// Addressing mode codes
// ****************************************************************
`define DPAX_MODE_W 3
`define DPAX_MODE_PLAIN 3'h0
`define DPAX_MODE_PREMOD 3'h1
`define DPAX_MODE_POSTMOD 3'h2
`define DPAX_MODE_REGOFS 3'h3
`define DPAX_MODE_MODULO 3'h4
`define DPAX_MODE_BITREV 3'h5

`endif

/* File: verif/dpax_chk_asserts.sv */
`timescale 1ns/1ps
`include "dpax_defines.vh"
// ****************************************************************
// Port checker for the page extension
// ****************************************************************
module dpax_chk_asserts (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // Core side.
  input wire rdPageWrEn,
  input wire wrPageWrEn,
  input wire [9:0] pageWrData,
  input wire accValid,
  input wire accWrite,
  input wire [2:0] accMode,
  input wire [15:0] baseEa,
  input wire accOverflow,
  input wire accUnderflow,
  // Results.
  input wire ansValid_q,
  input wire [15:0] ansEa_q,
  input wire [9:0] ansPage_q,
  input wire ansPaged_q,
  input wire addrErrTrap_q,
  input wire [9:0] readPageSelector_q,
  input wire [9:0] writePageSelector_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A load wins over a step, so stepping checks skip load cycles.
  wire calm = !rdPageWrEn && !wrPageWrEn;
  wire mdMod = accMode == `DPAX_MODE_PREMOD || accMode == `DPAX_MODE_POSTMOD;
  // Only the three in-page modes; the unused codes decode to nothing.
  wire mdWrap = accMode >= `DPAX_MODE_REGOFS && accMode <= `DPAX_MODE_BITREV;
  wire rdPg = accValid && calm && !accWrite && baseEa[15] && mdMod;
  answer_lat_a: assert property (accValid |=> ansValid_q)
    else $error("access got no answer");
  paged_flag_a: assert property (ansValid_q |-> ansPaged_q == ansEa_q[15])
    else $error("paged flag differs from address bit");
  zero_page_a: assert property (
    ansValid_q && ansPaged_q && ansPage_q == 10'h000 |-> addrErrTrap_q)
    else $error("zero page access without trap");
  prog_write_a: assert property (
    ansValid_q && $past(accWrite) && ansPaged_q && ansPage_q[9] |-> addrErrTrap_q)
    else $error("program space write without trap");
  wrap_keep_a: assert property (
    accValid && calm && baseEa[15] && mdWrap && (accOverflow || accUnderflow)
    |=> ansEa_q[15] ##1 $stable(readPageSelector_q) && $stable(writePageSelector_q))
    else $error("wrapping mode moved a selector");
  ovf_step_a: assert property (
    rdPg && accOverflow |=> (ansEa_q[15] && ansPage_q == readPageSelector_q + 10'h001)
    || (!ansEa_q[15] && ansPage_q == readPageSelector_q))
    else $error("overflow step wrong");
  unf_step_a: assert property (
    rdPg && accUnderflow |=> (ansEa_q[15] && ansPage_q == readPageSelector_q - 10'h001)
    || (!ansEa_q[15] && ansPage_q == readPageSelector_q))
    else $error("underflow step wrong");
  load_rd_a: assert property (
    rdPageWrEn |=> ##1 readPageSelector_q == $past(pageWrData, 2))
    else $error("read selector load lost");
endmodule
bind dpax_page_ext dpax_chk_asserts chk_u (.*);

/* File: verif/dpax_core_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Core address generation stand-in
// ****************************************************************
module dpax_core_model (
  // Clock.
  input wire sys_clk,
  // Selector loads and access request, all idle at time zero.
  output logic rdPageWrEn = 1'b0,
  output logic wrPageWrEn = 1'b0,
  output logic [9:0] pageWrData = 10'h000,
  output logic accValid = 1'b0,
  output logic accWrite = 1'b0,
  output logic [2:0] accMode = 3'h0,
  output logic [15:0] baseEa = 16'h0000,
  output logic [15:0] modEa = 16'h0000,
  output logic accOverflow = 1'b0,
  output logic accUnderflow = 1'b0
);
  // One-cycle selector load.
  task automatic ld(input logic wr, input logic [9:0] v);
    @(posedge sys_clk);
    #1;
    rdPageWrEn = !wr;
    wrPageWrEn = wr;
    pageWrData = v;
    @(posedge sys_clk);
    #1;
    rdPageWrEn = 1'b0;
    wrPageWrEn = 1'b0;
  endtask
  // One access with a tiny offset, so a crossing moves one page only.
  task automatic go(input logic w, input logic [2:0] m, input logic o, input logic u);
    @(posedge sys_clk);
    #1;
    accValid = 1'b1;
    accWrite = w;
    accMode = m;
    baseEa = 16'h8010;
    modEa = {!(o || u), 15'h0012};
    accOverflow = o;
    accUnderflow = u;
    @(posedge sys_clk);
    #1;
    accValid = 1'b0;
  endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`include "dpax_defines.vh"
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  wire rdPageWrEn, wrPageWrEn, accValid, accWrite, accOverflow, accUnderflow;
  wire ansValid_q, ansPaged_q, addrErrTrap_q;
  wire [9:0] pageWrData, ansPage_q, readPageSelector_q, writePageSelector_q;
  wire [2:0] accMode;
  wire [15:0] baseEa, modEa, ansEa_q;
  int nFail = 0;
  int testsRun = 0;
  logic [9:0] bp[7] = '{10'h1FF, 10'h3FF, 10'h2FF, 10'h001, 10'h200, 10'h300, 10'h1FF};
  logic [9:0] ep[7] = '{10'h1FF, 10'h3FF, 10'h300, 10'h001, 10'h200, 10'h2FF, 10'h1FF};
  always #10 sys_clk = ~sys_clk;
  dpax_core_model core_u (.*);
  dpax_page_ext dut_u (.*);
  task ck(input logic ok, input string m);
    testsRun++;
    if (!ok) begin
      nFail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // One access; page, address, paged flag and trap are judged every time.
  task acc(input logic w, input logic [2:0] m, input logic o, input logic u,
           input logic [9:0] p, input logic b, input logic t);
    core_u.go(w, m, o, u);
    ck(ansValid_q === 1'b1 && addrErrTrap_q === t && ansPage_q === p
       && ansEa_q === {b, 15'h0012} && ansPaged_q === b, "access result");
  endtask
  // A reset in mid-run brings both selectors back to page one.
  task t_reset;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    ck(readPageSelector_q === 10'h001 && writePageSelector_q === 10'h001, "reset");
    acc(1'b0, `DPAX_MODE_POSTMOD, 1'b1, 1'b0, 10'h002, 1'b1, 1'b0);
    $display("reset done");
  endtask
  task t_steps;
    ck(readPageSelector_q === 10'h001 && writePageSelector_q === 10'h001, "reset pages");
    core_u.ld(1'b0, 10'h005);
    core_u.ld(1'b1, 10'h123);
    @(posedge sys_clk);
    #1;
    ck(readPageSelector_q === 10'h005 && writePageSelector_q === 10'h123, "loads");
    acc(1'b0, `DPAX_MODE_POSTMOD, 1'b1, 1'b0, 10'h006, 1'b1, 1'b0);
    acc(1'b0, `DPAX_MODE_PREMOD, 1'b0, 1'b1, 10'h005, 1'b1, 1'b0);
    acc(1'b1, `DPAX_MODE_PREMOD, 1'b1, 1'b0, 10'h124, 1'b1, 1'b0);
    for (int m = 3; m < 6; m++) acc(1'b0, m[2:0], 1'b1, 1'b0, 10'h005, 1'b1, 1'b0);
    acc(1'b0, `DPAX_MODE_PLAIN, 1'b1, 1'b0, 10'h005, 1'b0, 1'b0);
    $display("steps done");
  endtask
  // Boundary table: entries 3 to 5 underflow, 2 and 5 keep bit 15, 6 writes.
  task t_bounds;
    logic [6:0] uu;
    logic [6:0] eb;
    uu = 7'h38;
    eb = 7'h24;
    for (int i = 0; i < 7; i++) begin
      core_u.ld(i == 6, bp[i]);
      acc(i == 6, `DPAX_MODE_POSTMOD, !uu[i], uu[i], ep[i], eb[i], 1'b0);
    end
    $display("bounds done");
  endtask
  task t_traps;
    core_u.ld(1'b1, 10'h000);
    acc(1'b1, `DPAX_MODE_POSTMOD, 1'b0, 1'b0, 10'h000, 1'b1, 1'b1);
    core_u.ld(1'b1, 10'h200);
    acc(1'b1, `DPAX_MODE_POSTMOD, 1'b0, 1'b0, 10'h200, 1'b1, 1'b1);
    core_u.ld(1'b0, 10'h250);
    core_u.ld(1'b1, 10'h050);
    acc(1'b0, `DPAX_MODE_POSTMOD, 1'b0, 1'b0, 10'h250, 1'b1, 1'b0);
    acc(1'b1, `DPAX_MODE_POSTMOD, 1'b0, 1'b0, 10'h050, 1'b1, 1'b0);
    $display("traps done");
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    @(posedge sys_clk);
    #1;
    t_steps;
    t_bounds;
    t_traps;
    t_reset;
    results;
  end
  // A hang is cut short well past the expected run of under a hundred cycles.
  initial begin
    #100000;
    nFail++;
    results;
  end
endmodule
